// ==== rtl/tcpwm_top.sv ====
// Purpose: Three channel PWM timer with period and duty compares.
// Assumes: Registers on a plain strobe port; read data one cycle later.
// Notes: With the clear bit set, a duty value above the period never matches, so pin stays off after the first period match.
`timescale 1ns/100ps
`include "tcpwm_defines.svh"
module tcpwm_top #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire tcpwm_pkg::tcpwm_bus_t bus_in,
  input wire logic cutoff_in,
  output logic [15:0] rdata_out,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic irq_out,
  output logic adc_trig_out
);
  import tcpwm_pkg::*;
  logic [15:0] ctrl, next_ctrl;
  logic [CNT_W-1:0] period_compare_reg, next_period;
  logic [CNT_W-1:0] duty_reg [3], next_duty [3];
  logic [CNT_W-1:0] pwm_counter, next_counter;
  logic [1:0] status, next_status;
  logic [1:0] mask, next_mask;
  logic [5:0] outcfg, next_outcfg;
  logic cutoff_en, next_cutoff_en;
  logic [2:0] level, next_level;
  logic [2:0] pins;
  logic [15:0] next_rdata;
  logic next_trig, trig;
  logic cut_s1, cut_s2;
  logic tick, per_match, wr, run;
  logic [2:0] duty_match;
  logic [2:0] pin_q;
  logic [2:0] next_pin_q;
  logic next_cut_s1, next_cut_s2, next_irq;
  assign wr = bus_in.wr;
  assign run = ctrl[`TCPWM_CTRL_RUN];
  tcpwm_tick u_tick (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .run_in(run),
    .src_in(tcpwm_src_t'(ctrl[`TCPWM_CTRL_SRC_HI:`TCPWM_CTRL_SRC_LO])),
    .tick_out(tick)
  );
  // All four compares look at the same counter value in one tick.
  assign per_match = tick && (pwm_counter == period_compare_reg);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      assign duty_match[gi] = tick && (pwm_counter == duty_reg[gi]);
      // Active level bit gi, initial level bit gi+3 (0 means inactive).
      assign pins[gi] = (cutoff_en && cut_s2) ? ~outcfg[gi] :
        (level[gi] ? outcfg[gi] : ~outcfg[gi]);
    end
  endgenerate
  always_comb begin
    next_ctrl = ctrl;
    next_period = period_compare_reg;
    next_duty = duty_reg;
    next_mask = mask;
    next_outcfg = outcfg;
    next_cutoff_en = cutoff_en;
    next_counter = pwm_counter;
    next_level = level;
    next_status = status;
    next_rdata = 16'h0000;
    if (wr) begin
      case (bus_in.addr)
        `TCPWM_OFF_CTRL: next_ctrl = {11'h000, bus_in.wdata[4:0]};
        `TCPWM_OFF_PERIOD: next_period = bus_in.wdata;
        `TCPWM_OFF_DUTY_B: next_duty[0] = bus_in.wdata;
        `TCPWM_OFF_DUTY_C: next_duty[1] = bus_in.wdata;
        `TCPWM_OFF_DUTY_D: next_duty[2] = bus_in.wdata;
        `TCPWM_OFF_MASK: next_mask = bus_in.wdata[1:0];
        `TCPWM_OFF_OUTCFG: next_outcfg = bus_in.wdata[5:0];
        `TCPWM_OFF_CUTOFF: next_cutoff_en = bus_in.wdata[0];
        `TCPWM_OFF_STATUS: next_status = status & ~bus_in.wdata[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    if (!run) begin
      // Stopped timer shows the initial levels again.
      next_level = outcfg[5:3];
    end else if (per_match) begin
      next_level = 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (duty_match[i]) begin
          next_level[i] = 1'b1;
        end
      end
    end
    if (wr && bus_in.addr == `TCPWM_OFF_COUNTER) begin
      next_counter = bus_in.wdata;
    end else if (per_match && ctrl[`TCPWM_CTRL_CLR]) begin
      next_counter = 16'h0000;
    end else if (tick) begin
      next_counter = pwm_counter + 16'h0001;
    end
    // Set wins over a clear written in the same cycle.
    if (per_match) begin
      next_status[`TCPWM_ST_PERIOD] = 1'b1;
    end
    if (cutoff_en && cut_s2) begin
      next_status[`TCPWM_ST_CUTOFF] = 1'b1;
    end
    next_trig = per_match && ctrl[`TCPWM_CTRL_ADTRG];
    // The cutoff pin is asynchronous, so only the second flop is read.
    next_cut_s1 = cutoff_in;
    next_cut_s2 = cut_s1;
    // Registered pins keep compare decode glitches away from the loads.
    next_pin_q = pins;
    next_irq = |(next_status & next_mask);
    if (bus_in.rd) begin
      case (bus_in.addr)
        `TCPWM_OFF_CTRL: next_rdata = ctrl;
        `TCPWM_OFF_PERIOD: next_rdata = period_compare_reg;
        `TCPWM_OFF_DUTY_B: next_rdata = duty_reg[0];
        `TCPWM_OFF_DUTY_C: next_rdata = duty_reg[1];
        `TCPWM_OFF_DUTY_D: next_rdata = duty_reg[2];
        `TCPWM_OFF_COUNTER: next_rdata = pwm_counter;
        `TCPWM_OFF_STATUS: next_rdata = {14'h0000, status};
        `TCPWM_OFF_MASK: next_rdata = {14'h0000, mask};
        `TCPWM_OFF_OUTCFG: next_rdata = {10'h000, outcfg};
        `TCPWM_OFF_CUTOFF: next_rdata = {15'h0000, cutoff_en};
        default: next_rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl <= `TCPWM_CTRL_RST;
      period_compare_reg <= `TCPWM_PERIOD_RST;
      duty_reg <= '{`TCPWM_DUTY_RST, `TCPWM_DUTY_RST, `TCPWM_DUTY_RST};
      pwm_counter <= 16'h0000;
      status <= 2'h0;
      mask <= 2'h0;
      outcfg <= 6'(`TCPWM_OUTCFG_RST);
      cutoff_en <= 1'b0;
      level <= 3'h0;
      rdata_out <= 16'h0000;
      trig <= 1'b0;
      cut_s1 <= 1'b0;
      cut_s2 <= 1'b0;
      pin_q <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      period_compare_reg <= next_period;
      duty_reg <= next_duty;
      pwm_counter <= next_counter;
      status <= next_status;
      mask <= next_mask;
      outcfg <= next_outcfg;
      cutoff_en <= next_cutoff_en;
      level <= next_level;
      rdata_out <= next_rdata;
      trig <= next_trig;
      cut_s1 <= next_cut_s1;
      cut_s2 <= next_cut_s2;
      pin_q <= next_pin_q;
      irq_out <= next_irq;
    end
  end
  assign pwm_out_b = pin_q[0];
  assign pwm_out_c = pin_q[1];
  assign pwm_out_d = pin_q[2];
  assign adc_trig_out = trig;
  // Assertions.
  property p_period_clear;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (per_match && ctrl[`TCPWM_CTRL_CLR] && !wr) |=>
      pwm_counter == 16'h0000;
  endproperty
  a_period_clear: assert property (p_period_clear)
    else $error("no clear");
  property p_pins_off;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (per_match && run && !cutoff_en) |=> ##1 (pin_q == ~outcfg[2:0]);
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins not off");
  property p_duty_on;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (duty_match[0] && !per_match && run && !cutoff_en && !wr) |=> ##1
      (pwm_out_b == outcfg[0]);
  endproperty
  a_duty_on: assert property (p_duty_on) else $error("duty not on");
  property p_irq;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (per_match && mask[0] && !wr) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_step;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (tick && !per_match && !wr) |=>
      pwm_counter == $past(pwm_counter) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_div1;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && ctrl[3:2] == 2'b00 && $past(run)) |-> tick;
  endproperty
  a_div1: assert property (p_div1) else $error("no tick");
  property p_cut;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (!cutoff_en && !$past(cutoff_en) && $past(level[0]) && $stable(outcfg))
      |-> pwm_out_b == outcfg[0];
  endproperty
  a_cut: assert property (p_cut) else $error("cutoff leak");
  property p_trig;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    adc_trig_out |-> $past(per_match) && $past(ctrl[`TCPWM_CTRL_ADTRG]);
  endproperty
  a_trig: assert property (p_trig) else $error("bad trigger");
  property p_init;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (!run && !cutoff_en) |=> level == $past(outcfg[5:3]);
  endproperty
  a_init: assert property (p_init) else $error("bad init");
  property p_per;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && ctrl[`TCPWM_CTRL_CLR] && !wr &&
      pwm_counter <= period_compare_reg) |=> pwm_counter <= period_compare_reg;
  endproperty
  a_per: assert property (p_per) else $error("bad period");
  property p_duty;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (run && !per_match && !duty_match[1]) |=> level[1] == $past(level[1]);
  endproperty
  a_duty: assert property (p_duty) else $error("bad duty");
  property p_trig_off;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !ctrl[`TCPWM_CTRL_ADTRG] |=> !adc_trig_out;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trig leak");
  property p_cut_force;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (cutoff_en && cut_s2 && !wr) |=> pin_q == ~outcfg[2:0];
  endproperty
  a_cut_force: assert property (p_cut_force) else $error("not cut");
  c_period: cover property (@(posedge clk_sys_in) per_match);
  c_duty: cover property (@(posedge clk_sys_in)
    duty_match[2] ##[1:40] per_match);
  c_wrap: cover property (@(posedge clk_sys_in)
    per_match && !ctrl[`TCPWM_CTRL_CLR]);
  c_cutoff: cover property (@(posedge clk_sys_in) cutoff_en && cut_s2);
  c_irq: cover property (@(posedge clk_sys_in) $rose(irq_out));
endmodule

// ==== pkg/tcpwm_defines.svh ====
// Purpose: Register offsets, field positions, reset values and counts.
// Assumes: Included by its bare name.
// Notes: Word offsets on the plain register port.
`ifndef TCPWM_DEFINES_SVH
`define TCPWM_DEFINES_SVH
`define TCPWM_OFF_CTRL 4'h0
`define TCPWM_OFF_PERIOD 4'h1
`define TCPWM_OFF_DUTY_B 4'h2
`define TCPWM_OFF_DUTY_C 4'h3
`define TCPWM_OFF_DUTY_D 4'h4
`define TCPWM_OFF_COUNTER 4'h5
`define TCPWM_OFF_STATUS 4'h6
`define TCPWM_OFF_MASK 4'h7
`define TCPWM_OFF_OUTCFG 4'h8
`define TCPWM_OFF_CUTOFF 4'h9
`define TCPWM_CTRL_RUN 0
`define TCPWM_CTRL_CLR 1
`define TCPWM_CTRL_SRC_LO 2
`define TCPWM_CTRL_SRC_HI 3
`define TCPWM_CTRL_ADTRG 4
`define TCPWM_ST_PERIOD 0
`define TCPWM_ST_CUTOFF 1
`define TCPWM_CTRL_RST 16'h0002
`define TCPWM_PERIOD_RST 16'hFFFF
`define TCPWM_DUTY_RST 16'hFFFF
`define TCPWM_OUTCFG_RST 16'h0007
`define TCPWM_DIV_SRC1 8'h01
`define TCPWM_DIV_SRC2 8'h02
`define TCPWM_DIV_SRC3 8'h08
`define TCPWM_DIV_SRC4 8'h20
`endif

// ==== pkg/tcpwm_pkg.sv ====
// Purpose: Types for the three channel PWM timer.
// Assumes: Counter width of 16 bits.
// Notes: Count source select and register bus carrier.
package tcpwm_pkg;
  typedef enum logic [1:0] {
    tcpwm_src_div1,
    tcpwm_src_div2,
    tcpwm_src_div8,
    tcpwm_src_div32
  } tcpwm_src_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tcpwm_bus_t;
endpackage

// ==== rtl/tcpwm_tick.sv ====
// Purpose: Count source tick generator.
// Assumes: One clock; output is a one cycle enable.
// Notes: Divide by one gives a tick on every clock.
`timescale 1ns/100ps
`include "tcpwm_defines.svh"
module tcpwm_tick (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire tcpwm_pkg::tcpwm_src_t src_in,
  output logic tick_out
);
  import tcpwm_pkg::*;
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic [7:0] limit;
  always_comb begin
    case (src_in)
      tcpwm_src_div1: limit = `TCPWM_DIV_SRC1;
      tcpwm_src_div2: limit = `TCPWM_DIV_SRC2;
      tcpwm_src_div8: limit = `TCPWM_DIV_SRC3;
      tcpwm_src_div32: limit = `TCPWM_DIV_SRC4;
      default: limit = `TCPWM_DIV_SRC1;
    endcase
    next_div_cnt = div_cnt;
    tick_out = 1'b0;
    if (run_in) begin
      if (div_cnt >= limit - 8'h01) begin
        next_div_cnt = 8'h00;
        tick_out = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end else begin
      next_div_cnt = 8'h00;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end
endmodule

// ==== bench/tcpwm_load.sv ====
// Purpose: Load on one PWM pin that measures each active high span.
// Assumes: The pin is set up active high.
// Notes: A span is latched when the pin falls, so a cut span still counts.
`timescale 1ns/100ps
module tcpwm_load (
  input wire logic clk_sys_in,
  input wire logic pin_in,
  output logic [15:0] on_len_out,
  output logic done_out
);
  logic [15:0] run_len = 16'h0000;
  logic pin_d = 1'b0;
  always @(posedge clk_sys_in) begin
    pin_d <= pin_in;
    done_out <= pin_d & ~pin_in;
    run_len <= pin_in ? run_len + 16'h0001 : 16'h0000;
    if (pin_d & ~pin_in) on_len_out <= run_len;
  end
endmodule

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the three channel PWM timer.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: Spans and gaps are judged only after a setting has settled.
`timescale 1ns/100ps
`include "tcpwm_defines.svh"
module tb_top;
  import tcpwm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  tcpwm_bus_t bus_in = '0;
  logic cutoff_in = 1'b0;
  logic [15:0] rdata_out, len_b, len_c, len_d;
  logic pwm_out_b, pwm_out_c, pwm_out_d, irq_out, adc_trig_out;
  logic done_b, done_c, done_d;
  logic [15:0] exp_q[$];
  logic [15:0] exp_b, exp_c, exp_d, exp_gap;
  logic rd_d = 1'b0;
  logic chk = 1'b0;
  logic cut_on = 1'b0;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 20495;
  int cyc = 0;
  int last_trig = 0;
  int divs[4] = '{1, 2, 8, 32};
  int prd = 9;
  int duty[3];
  logic [15:0] cfgs[4] = '{16'h0000, 16'h0038, 16'h003F, 16'h0007};
  logic [15:0] pexp[4] = '{16'h0007, 16'h0000, 16'h0007, 16'h0000};

  always #10 clk_sys_in = ~clk_sys_in;

  tcpwm_top dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .bus_in(bus_in), .cutoff_in(cutoff_in), .rdata_out(rdata_out),
    .pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d),
    .irq_out(irq_out), .adc_trig_out(adc_trig_out));
  tcpwm_load ld_b (.clk_sys_in(clk_sys_in), .pin_in(pwm_out_b),
    .on_len_out(len_b), .done_out(done_b));
  tcpwm_load ld_c (.clk_sys_in(clk_sys_in), .pin_in(pwm_out_c),
    .on_len_out(len_c), .done_out(done_c));
  tcpwm_load ld_d (.clk_sys_in(clk_sys_in), .pin_in(pwm_out_d),
    .on_len_out(len_d), .done_out(done_d));

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Each access leaves one idle cycle so no strobe is assigned twice.
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus_in <= '0;
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk_sys_in);
    exp_q.push_back(e);
    bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus_in <= '0;
  endtask

  function automatic logic [15:0] pins();
    return {13'h0000, pwm_out_b, pwm_out_c, pwm_out_d};
  endfunction

  // The cutoff pin toggles at random while its function is off.
  always @(posedge clk_sys_in) begin
    cutoff_in <= cut_on ? 1'b1 : 1'($random(seed));
  end

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    rd_d <= bus_in.rd;
    if (rd_d) check("rdata", rdata_out, exp_q.pop_front());
    if (adc_trig_out) last_trig <= cyc;
    if (chk && adc_trig_out)
      check("trig_gap", 16'(cyc - last_trig), exp_gap);
    if (chk && done_b) check("span_b", len_b, exp_b);
    if (chk && done_c) check("span_c", len_c, exp_c);
    if (chk && done_d) check("span_d", len_d, exp_d);
  end

  initial begin
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check("rst_pins", pins(), 16'h0000);
    rd(`TCPWM_OFF_CTRL, `TCPWM_CTRL_RST);
    rd(`TCPWM_OFF_PERIOD, `TCPWM_PERIOD_RST);
    rd(`TCPWM_OFF_DUTY_C, `TCPWM_DUTY_RST);
    rd(`TCPWM_OFF_OUTCFG, `TCPWM_OUTCFG_RST);
    rd(4'hF, 16'h0000);
    foreach (cfgs[i]) begin
      wr(`TCPWM_OFF_OUTCFG, cfgs[i]);
      repeat (3) @(posedge clk_sys_in);
      check("idle_pins", pins(), pexp[i]);
    end
    wr(`TCPWM_OFF_PERIOD, 16'(prd));
    for (int i = 0; i < 3; i++) begin
      duty[i] = $unsigned($random(seed)) % prd;
      wr(`TCPWM_OFF_DUTY_B + 4'(i), 16'(duty[i]));
    end
    wr(`TCPWM_OFF_MASK, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      chk <= 1'b0;
      wr(`TCPWM_OFF_CTRL, 16'h0013 | (16'(s) << 2));
      exp_gap <= 16'(divs[s] * (prd + 1));
      exp_b <= 16'(divs[s] * (prd - duty[0]));
      exp_c <= 16'(divs[s] * (prd - duty[1]));
      exp_d <= 16'(divs[s] * (prd - duty[2]));
      repeat (2 * divs[s] * (prd + 1) + 8) @(posedge clk_sys_in);
      chk <= 1'b1;
      repeat (3 * divs[s] * (prd + 1)) @(posedge clk_sys_in);
    end
    chk <= 1'b0;
    check("irq_on", {15'h0000, irq_out}, 16'h0001);
    rd(`TCPWM_OFF_STATUS, 16'h0001);
    wr(`TCPWM_OFF_MASK, 16'h0000);
    repeat (3) @(posedge clk_sys_in);
    check("irq_mask", {15'h0000, irq_out}, 16'h0000);
    wr(`TCPWM_OFF_CTRL, 16'h0002);
    wr(`TCPWM_OFF_STATUS, 16'h0001);
    wr(`TCPWM_OFF_MASK, 16'h0001);
    repeat (3) @(posedge clk_sys_in);
    check("irq_clr", {15'h0000, irq_out}, 16'h0000);
    // Without the clear bit the counter runs on past the period match.
    wr(`TCPWM_OFF_COUNTER, 16'h0008);
    wr(`TCPWM_OFF_CTRL, 16'h0001);
    repeat (3) @(posedge clk_sys_in);
    wr(`TCPWM_OFF_CTRL, 16'h0002);
    rd(`TCPWM_OFF_COUNTER, 16'h000D);
    wr(`TCPWM_OFF_COUNTER, 16'h0005);
    rd(`TCPWM_OFF_COUNTER, 16'h0005);
    cut_on <= 1'b1;
    wr(`TCPWM_OFF_CUTOFF, 16'h0001);
    wr(`TCPWM_OFF_CTRL, 16'h0003);
    repeat (20) @(posedge clk_sys_in);
    repeat (30) begin
      @(posedge clk_sys_in);
      check("cut_pins", pins(), 16'h0000);
      check("trig_off", {15'h0000, adc_trig_out}, 16'h0000);
    end
    rd(`TCPWM_OFF_STATUS, 16'h0003);
    repeat (3) @(posedge clk_sys_in);
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
